// ==== bench/ahb_master_model.sv ====
// Bus master model: issues AHB-Lite address phases.
// Assumes the bench calls put from one thread.
`timescale 1ns/100ps
module ahb_master_model (
    // Clock
    input wire logic clk_sys,
    // Address phase
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hready
);
    initial begin
        haddr = 32'h00000000;
        htrans = 2'h0;
        hready = 1'b1;
    end
    // Held until the following edge samples it
    task automatic put(input logic [31:0] a, input logic [1:0] t, input logic r);
        @(posedge clk_sys);
        haddr <= a;
        htrans <= t;
        hready <= r;
    endtask
endmodule // ahb_master_model

// ==== bench/sample_map_properties.sv ====
// Checker: decode, remap and interrupt relations at the map's ports.
// Assumes bind onto sample_address_map, one clock domain.
`timescale 1ns/100ps
module sample_map_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bus side
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic boardConfigSwitch,
    // Sources
    input wire logic uartRxReadyIrq,
    input wire logic timerExpiredIrq,
    input wire logic analogBlockIrq,
    input wire logic pwmIrq,
    input wire logic [3:0] irqEnable,
    // Watched
    input wire sample_map_pkg::ahb_sel_t ahbSel,
    input wire logic [7:0] apbSel,
    input wire logic decodeError,
    input wire logic remapActive,
    input wire logic sharedProcessorIrq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic go = hready && htrans[1];
    wire logic [3:0] slot = haddr[31:28];
    wire logic [3:0] srcVec = {pwmIrq, analogBlockIrq, timerExpiredIrq, uartRxReadyIrq};
    // Switch held steady so the synced level is unambiguous
    a_low_slot_swap: assert property (go && slot == 4'h0 ##1 $stable(remapActive) |->
        ahbSel == (remapActive ? 4'h8 : 4'h4)) else $error("low slot wrong");
    a_high_slot_swap: assert property (go && slot == 4'h1 ##1 $stable(remapActive) |->
        ahbSel == (remapActive ? 4'h4 : 4'h8)) else $error("high slot wrong");
    a_int_flash_slot: assert property (go && slot == 4'h2 |=>
        ahbSel == 4'h2 && apbSel == 8'h00) else $error("flash slot wrong");
    a_apb_one_hot: assert property (go && slot == 4'hA && !haddr[27] |=>
        ahbSel == 4'h1 && apbSel == (8'h01 << $past(haddr[26:24]))) else $error("apb slot wrong");
    a_decode_miss: assert property (go && slot inside {[4'h3:4'h9], [4'hB:4'hF]} |=>
        decodeError && ahbSel == 4'h0) else $error("miss not flagged");
    a_idle_quiet: assert property (!go |=>
        ahbSel == 4'h0 && apbSel == 8'h00 && !decodeError) else $error("idle not quiet");
    // Sources reach the line three edges late, enables one edge late
    a_irq_raise: assert property ((|($past(srcVec, 3) & $past(irqEnable))) |->
        sharedProcessorIrq) else $error("irq missing");
    a_irq_clear: assert property (!(|($past(srcVec, 3) & $past(irqEnable))) |->
        !sharedProcessorIrq) else $error("irq stuck");
endmodule // sample_map_properties

bind sample_address_map sample_map_properties CHK (.clk_sys, .rst, .haddr, .htrans, .hready,
    .boardConfigSwitch, .uartRxReadyIrq, .timerExpiredIrq, .analogBlockIrq, .pwmIrq,
    .irqEnable, .ahbSel, .apbSel, .decodeError, .remapActive, .sharedProcessorIrq);

// ==== bench/sample_system_address_map_remap_test.sv ====
// Bench: every slot under both switch settings, refusals, interrupt mixes.
// Assumes the master model and the bound checker.
`timescale 1ns/100ps
module sample_system_address_map_remap_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sw = 1'b0;
    logic [3:0] src = 4'h0;
    logic [3:0] en = 4'h0;
    logic [31:0] haddr, a;
    logic [1:0] htrans;
    logic hready, decodeError, remapActive, sharedProcessorIrq;
    sample_map_pkg::ahb_sel_t ahbSel;
    logic [7:0] apbSel;
    logic [12:0] e;
    int fails = 0;
    int comparisons = 0;
    always #2.5 clk_sys = ~clk_sys;
    ahb_master_model MST (.clk_sys, .haddr, .htrans, .hready);
    sample_address_map DUT (.clk_sys, .rst, .haddr, .htrans, .hready, .boardConfigSwitch(sw),
        .uartRxReadyIrq(src[0]), .timerExpiredIrq(src[1]), .analogBlockIrq(src[2]),
        .pwmIrq(src[3]), .irqEnable(en), .ahbSel, .apbSel, .decodeError, .remapActive,
        .sharedProcessorIrq);
    function automatic logic [12:0] expected_map(input logic [31:0] x, input logic r);
        case (x[31:28])
            4'h0: return r ? 13'h1000 : 13'h0800;
            4'h1: return r ? 13'h0800 : 13'h1000;
            4'h2: return 13'h0400;
            4'hA: return x[27] ? 13'h0001 : {4'h1, 8'h01 << x[26:24], 1'b0};
            default: return 13'h0001;
        endcase
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic test_done;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(4069));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            sw <= r[0];
            repeat (4) @(posedge clk_sys);
            check(remapActive, r[0]);
            for (int s = 0; s < 32; s++) begin
                a = s < 16 ? {s[3:0], 28'($urandom)} : {4'hA, s[3:0], 24'($urandom)};
                MST.put(a, {1'b1, 1'($urandom)}, 1'b1);
                @(posedge clk_sys);
                #1;
                e = expected_map(a, r[0]);
                if (e[0])
                    check(decodeError, 1'b1);
                else
                    check({ahbSel, apbSel, decodeError}, e);
            end
        end
        // Busy transfer, then a stalled one
        for (int k = 0; k < 2; k++) begin
            MST.put(32'h20000000, k[0] ? 2'h2 : 2'h1, ~k[0]);
            @(posedge clk_sys);
            #1;
            check({ahbSel, apbSel, decodeError}, 13'h0000);
        end
        // Each source alone, each masked alone, then random mixes
        for (int i = 0; i < 32; i++) begin
            @(posedge clk_sys);
            src <= i < 8 ? 4'h1 << i[1:0] : 4'($urandom);
            en <= i < 4 ? 4'h1 << i[1:0] : (i < 8 ? ~(4'h1 << i[1:0]) : 4'($urandom));
            repeat (4) @(posedge clk_sys);
            #1;
            check(sharedProcessorIrq, |(src & en));
        end
        test_done();
    end
    initial begin
        #20000;
        fails++;
        test_done();
    end
endmodule // sample_system_address_map_remap_test

// ==== rtl/irq_combiner.sv ====
// Interrupt controller: folds the enabled pending sources onto one line.
// Assumes source levels already synchronous to clk_sys.
`timescale 1ns/100ps
module irq_combiner (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Sources and enables
    input wire logic [3:0] pending,
    input wire logic [3:0] enable,
    // Shared line
    output logic sharedProcessorIrq
);

    logic next_sharedProcessorIrq;

    always_comb begin
        next_sharedProcessorIrq = |(pending & enable);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sharedProcessorIrq <= 1'b0;
        end else begin
            sharedProcessorIrq <= next_sharedProcessorIrq;
        end
    end

endmodule // irq_combiner

// ==== rtl/sample_address_map.sv ====
// Address decode, memory remap and interrupt aggregation of the sample subsystem.
// Assumes an AHB-Lite master on clk_sys and the board switch arriving asynchronously.
//
// Functional notes
// - Each address picks a slave slot from its position on the AHB or APB bus.
// - Remap on: external flash at 0x00000000, external SRAM at 0x10000000.
// - Remap off: external SRAM at 0x00000000, external flash at 0x10000000.
// - Remap only swaps who answers AHB slots 0 and 1; others unchanged.
// - Internal flash at 0x20000000; APB peripherals from 0xA0000000 in 16 MB steps.
// - All slow peripherals sit behind one AHB-to-APB bridge slot.
// - Four sources share one processor interrupt through the controller.
// - Sources: uart receive ready, timer expired, analog block, pwm.
`timescale 1ns/100ps
module sample_address_map (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AHB-Lite address phase from the processor
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hready,
    // Board switch, asynchronous
    input wire logic boardConfigSwitch,
    // Interrupt sources and enables
    input wire logic uartRxReadyIrq,
    input wire logic timerExpiredIrq,
    input wire logic analogBlockIrq,
    input wire logic pwmIrq,
    input wire logic [3:0] irqEnable,
    // Slave selects
    output sample_map_pkg::ahb_sel_t ahbSel,
    output logic [7:0] apbSel,
    output logic decodeError,
    output logic remapActive,
    // Processor interrupt
    output logic sharedProcessorIrq
);

    // Synchroniser stages
    logic switchMeta;
    logic switchSync;
    sample_map_pkg::irq_src_t srcMeta;
    sample_map_pkg::irq_src_t srcSync;
    logic next_switchMeta;
    logic next_switchSync;
    sample_map_pkg::irq_src_t next_srcMeta;
    sample_map_pkg::irq_src_t next_srcSync;
    // Address phase view
    logic phaseTaken;
    logic [3:0] ahbSlot;
    logic [3:0] apbSlot;
    // Registered selects
    sample_map_pkg::ahb_sel_t next_ahbSel;
    logic [7:0] next_apbSel;
    logic next_decodeError;
    // Registered switch level
    logic next_remapActive;
    // Sources after synchronisation
    logic [3:0] pendingSrc;

    function automatic logic [3:0] ahb_slot_of(input logic [31:0] addr);
        return addr[sample_map_pkg::AHB_SLOT_MSB:sample_map_pkg::AHB_SLOT_LSB];
    endfunction

    function automatic logic [3:0] apb_slot_of(input logic [31:0] addr);
        return addr[sample_map_pkg::APB_SLOT_MSB:sample_map_pkg::APB_SLOT_LSB];
    endfunction

    // Slots past the last peripheral give no select
    function automatic logic [7:0] apb_onehot(input logic [3:0] slot);
        logic [7:0] sel;
        sel = 8'h00;
        if (slot < 4'(sample_map_pkg::NUM_APB_SLOTS)) begin
            sel[slot[2:0]] = 1'b1;
        end
        return sel;
    endfunction

    function automatic sample_map_pkg::ahb_sel_t ahb_route(input logic [3:0] slot, input logic remap);
        sample_map_pkg::ahb_sel_t sel;
        sel = '0;
        case (slot)
            sample_map_pkg::SLOT_LOW_MEM: begin
                // Swap of slots 0 and 1 only
                if (remap) begin
                    sel.extFlash = 1'b1;
                end else begin
                    sel.extSram = 1'b1;
                end
            end
            sample_map_pkg::SLOT_HIGH_MEM: begin
                if (remap) begin
                    sel.extSram = 1'b1;
                end else begin
                    sel.extFlash = 1'b1;
                end
            end
            sample_map_pkg::SLOT_INT_FLASH: begin
                sel.intFlash = 1'b1;
            end
            sample_map_pkg::SLOT_APB_BRIDGE: begin
                sel.apbBridge = 1'b1;
            end
            default: begin
                sel = '0;
            end
        endcase
        return sel;
    endfunction

    // Holes answer with an error rather than hang the bus
    function automatic logic decode_hole(input logic [3:0] aSlot, input logic [3:0] pSlot);
        logic hole;
        hole = 1'b1;
        case (aSlot)
            sample_map_pkg::SLOT_LOW_MEM: begin
                hole = 1'b0;
            end
            sample_map_pkg::SLOT_HIGH_MEM: begin
                hole = 1'b0;
            end
            sample_map_pkg::SLOT_INT_FLASH: begin
                hole = 1'b0;
            end
            sample_map_pkg::SLOT_APB_BRIDGE: begin
                hole = (apb_onehot(pSlot) == 8'h00);
            end
            default: begin
                hole = 1'b1;
            end
        endcase
        return hole;
    endfunction

    // Switch and sources come from outside the clock domain
    always_comb begin
        next_switchMeta = boardConfigSwitch;
        next_switchSync = switchMeta;
        next_srcMeta.uartRxReady = uartRxReadyIrq;
        next_srcMeta.timerExpired = timerExpiredIrq;
        next_srcMeta.analogBlock = analogBlockIrq;
        next_srcMeta.pwm = pwmIrq;
        next_srcSync = srcMeta;
    end

    // Only the second stage is read outside this group
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            switchMeta <= 1'b0;
            switchSync <= 1'b0;
            srcMeta <= '0;
            srcSync <= '0;
        end else begin
            switchMeta <= next_switchMeta;
            switchSync <= next_switchSync;
            srcMeta <= next_srcMeta;
            srcSync <= next_srcSync;
        end
    end

    // Taken when ready with a non-sequential or sequential transfer
    always_comb begin
        phaseTaken = hready && htrans[1];
        ahbSlot = ahb_slot_of(haddr);
        apbSlot = apb_slot_of(haddr);
    end

    // Recomputed every cycle, so idle and busy phases clear the selects
    always_comb begin
        next_ahbSel = '0;
        next_apbSel = 8'h00;
        next_decodeError = 1'b0;
        if (phaseTaken) begin
            next_ahbSel = ahb_route(ahbSlot, switchSync);
            if (ahbSlot == sample_map_pkg::SLOT_APB_BRIDGE) begin
                next_apbSel = apb_onehot(apbSlot);
            end
            next_decodeError = decode_hole(ahbSlot, apbSlot);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ahbSel <= '0;
            apbSel <= 8'h00;
            decodeError <= 1'b0;
        end else begin
            ahbSel <= next_ahbSel;
            apbSel <= next_apbSel;
            decodeError <= next_decodeError;
        end
    end

    // Same synced level as the decode, so the flag never leads the swap
    always_comb begin
        next_remapActive = switchSync;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            remapActive <= 1'b0;
        end else begin
            remapActive <= next_remapActive;
        end
    end

    // Enables skip the synchronisers; sources lag two cycles behind their pins
    always_comb begin
        pendingSrc = 4'h0;
        pendingSrc[sample_map_pkg::IRQ_UART_RX] = srcSync.uartRxReady;
        pendingSrc[sample_map_pkg::IRQ_TIMER] = srcSync.timerExpired;
        pendingSrc[sample_map_pkg::IRQ_ANALOG] = srcSync.analogBlock;
        pendingSrc[sample_map_pkg::IRQ_PWM] = srcSync.pwm;
    end

    irq_combiner u_irq (
        .clk_sys(clk_sys),
        .rst(rst),
        .pending(pendingSrc),
        .enable(irqEnable),
        .sharedProcessorIrq(sharedProcessorIrq)
    );

endmodule // sample_address_map

// ==== rtl/sample_map_pkg.sv ====
// Package: address map, slot numbers and interrupt source layout.
// Assumes a 32-bit AHB-Lite address bus and one system clock.
package sample_map_pkg;

    localparam int ADDR_W = 32;
    localparam int NUM_AHB_SLOTS = 4;
    localparam int NUM_APB_SLOTS = 8;
    localparam int NUM_IRQ_SRC = 4;

    // AHB slots sit on 256 MB boundaries
    localparam int AHB_SLOT_MSB = 31;
    localparam int AHB_SLOT_LSB = 28;
    // APB slots sit on 16 MB steps inside the bridge window
    localparam int APB_SLOT_MSB = 27;
    localparam int APB_SLOT_LSB = 24;

    localparam logic [3:0] SLOT_LOW_MEM = 4'h0;
    localparam logic [3:0] SLOT_HIGH_MEM = 4'h1;
    localparam logic [3:0] SLOT_INT_FLASH = 4'h2;
    localparam logic [3:0] SLOT_APB_BRIDGE = 4'hA;

    localparam logic [31:0] BASE_LOW_MEM = 32'h00000000;
    localparam logic [31:0] BASE_HIGH_MEM = 32'h10000000;
    localparam logic [31:0] BASE_INT_FLASH = 32'h20000000;
    localparam logic [31:0] BASE_APB = 32'hA0000000;
    localparam logic [31:0] BASE_ANALOG = 32'hA7000000;

    // APB peripheral slot order
    localparam logic [2:0] APB_PWM = 3'h0;
    localparam logic [2:0] APB_UART = 3'h1;
    localparam logic [2:0] APB_TIMER = 3'h2;
    localparam logic [2:0] APB_INTC = 3'h3;
    localparam logic [2:0] APB_REMAP = 3'h4;
    localparam logic [2:0] APB_GPIO = 3'h5;
    localparam logic [2:0] APB_GPIO2 = 3'h6;
    localparam logic [2:0] APB_ANALOG = 3'h7;

    // Interrupt source bit positions
    localparam int IRQ_UART_RX = 0;
    localparam int IRQ_TIMER = 1;
    localparam int IRQ_ANALOG = 2;
    localparam int IRQ_PWM = 3;

    localparam logic [3:0] IRQ_ENABLE_RESET = 4'hF;

    typedef struct packed {
        logic extFlash;
        logic extSram;
        logic intFlash;
        logic apbBridge;
    } ahb_sel_t;

    // Field order follows the source bit positions above
    typedef struct packed {
        logic pwm;
        logic analogBlock;
        logic timerExpired;
        logic uartRxReady;
    } irq_src_t;

endpackage
